// [src/current_load_integrator.sv]
// Current-load integral with nominal-current clamp
`timescale 1ns/1ns
module current_load_integrator (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic cycle_tick,
   input wire logic [servo_limit_pkg::CUR_W-1:0] cur_abs,
   input wire logic [servo_limit_pkg::CUR_W-1:0] nom_cur,
   input wire logic [servo_limit_pkg::LOAD_W-1:0] load_step,
   output logic [servo_limit_pkg::LOAD_W-1:0] load,
   output logic clamp
);
   typedef struct packed {
      logic [servo_limit_pkg::LOAD_W-1:0] load;
      logic clamp;
   } il_state_t;
   il_state_t st;
   il_state_t next_st;
   logic [servo_limit_pkg::LOAD_W:0] sum;

   // Integrate once per control cycle, saturating at both ends
   always_comb begin
      next_st = st;
      sum = '0;
      if (cycle_tick) begin
         if (cur_abs > nom_cur) begin
            sum = {1'b0, st.load} + {1'b0, load_step}; // RULE_01 RULE_03
            if (sum >= {1'b0, servo_limit_pkg::LOAD_FULL}) begin
               next_st.load = servo_limit_pkg::LOAD_FULL; // RULE_20
            end else begin
               next_st.load = sum[servo_limit_pkg::LOAD_W-1:0];
            end
         end else if (cur_abs < nom_cur) begin
            if (st.load > load_step) begin
               next_st.load = st.load - load_step; // RULE_02
            end else begin
               next_st.load = '0; // RULE_20
            end
         end
      end
      // Clamp at full, released only once empty
      if (next_st.load == servo_limit_pkg::LOAD_FULL) begin
         next_st.clamp = 1'b1; // RULE_04
      end else if (next_st.load == '0) begin
         next_st.clamp = 1'b0; // RULE_05
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign load = st.load;
   assign clamp = st.clamp;
endmodule : current_load_integrator

// [src/servo_limit_pkg.sv]
// Constants shared by the servo limit supervisor
package servo_limit_pkg;
   // Data widths
   localparam int CUR_W = 16;
   localparam int SPD_W = 24;
   localparam int POS_W = 32;
   localparam int PCT_W = 16;
   localparam int LOAD_W = 32;
   // Percent scale: 10000 = 100.00 %
   localparam logic [PCT_W-1:0] PCT_FULL = 16'h2710;
   localparam logic [PCT_W-1:0] OVR_RESET = 16'h2710;
   // 95.00 % of set-up speed, leaving the speed controller its reserve
   localparam logic [PCT_W-1:0] RESERVE_KEEP = 16'h251c;
   // Full load of the current-load integral
   localparam logic [LOAD_W-1:0] LOAD_FULL = 32'h4000_0000;
   // Load time constant in ms and the clock rate
   localparam int CLK_HZ = 50_000_000;
   localparam int LOAD_TIME_MS = 2000;
   localparam longint LOAD_TIME_CYC = longint'(LOAD_TIME_MS) * CLK_HZ / 1000;
   // Register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_NOM_CUR = 8'h04;
   localparam logic [7:0] REG_MAX_CUR = 8'h08;
   localparam logic [7:0] REG_LOAD_STEP = 8'h0c;
   localparam logic [7:0] REG_SPD_POS = 8'h10;
   localparam logic [7:0] REG_SPD_NEG = 8'h14;
   localparam logic [7:0] REG_OVERRIDE = 8'h18;
   localparam logic [7:0] REG_SETUP_PCT = 8'h1c;
   localparam logic [7:0] REG_OVERSPEED = 8'h20;
   localparam logic [7:0] REG_ENC_TOL = 8'h24;
   localparam logic [7:0] REG_FOLLOW = 8'h28;
   localparam logic [7:0] REG_DEC_QSTOP = 8'h2c;
   localparam logic [7:0] REG_DEC_LIMSW = 8'h30;
   localparam logic [7:0] REG_DEC_RANGE = 8'h34;
   localparam logic [7:0] REG_STATUS = 8'h38;
   localparam logic [7:0] REG_LOAD = 8'h3c;
   localparam logic [7:0] REG_SPD_LIM = 8'h40;
   // Control register fields
   localparam int CTRL_POS_MODE = 0;
   localparam int CTRL_TRQ_SETPT = 1;
   localparam int CTRL_ENC_DIFF = 2;
   localparam int CTRL_HOMING = 3;
   // Status register fields
   localparam int ST_CLAMP = 0;
   localparam int ST_OVERSPEED = 1;
   localparam int ST_ENC_DIFF = 2;
   localparam int ST_FOLLOW = 3;
   localparam int ST_SETUP = 4;
   // Reset values
   localparam logic [CUR_W-1:0] NOM_CUR_RST = 16'h0100;
   localparam logic [CUR_W-1:0] MAX_CUR_RST = 16'h0200;
   localparam logic [SPD_W-1:0] SPD_LIM_RST = 24'h00_1000;
   localparam logic [SPD_W-1:0] OVERSPEED_RST = 24'h00_2000;
   localparam logic [PCT_W-1:0] SETUP_PCT_RST = 16'h03e8;
   localparam logic [POS_W-1:0] ENC_TOL_RST = 32'h0000_1000;
   localparam logic [POS_W-1:0] FOLLOW_RST = 32'h0000_8000;
   localparam logic [SPD_W-1:0] DEC_RST = 24'h00_0100;
endpackage : servo_limit_pkg

// [src/servo_limit_supervisor.sv]
// Servo limit supervisor: load clamp, speed limits, override and monitors
// Function
// RULE_01 - Load integral rises above nominal current
// RULE_02 - Load integral falls below nominal current
// RULE_03 - Integral reaches full within load time
// RULE_04 - At full load clamp current to nominal
// RULE_05 - Release clamp only after load reaches zero
// RULE_06 - Positioning speed multiplied by override factor
// RULE_07 - Override applies to sets and homing
// RULE_08 - Override resets to full scale
// RULE_09 - Overspeed error above threshold
// RULE_10 - Encoder difference error beyond tolerance
// RULE_11 - Torque limit by motor currents or setpoint
// RULE_12 - Positive speed capped by limit, override, setup
// RULE_13 - Negative speed capped by limit, override, setup
// RULE_14 - Setup speed is percent of smaller limit
// RULE_15 - Speed mode setup clamps speed setpoint
// RULE_16 - Positioning setup keeps five percent reserve
// RULE_17 - Controller drives setup input to enable
// RULE_18 - Following error fault beyond threshold
// RULE_19 - Separate decelerations for three stop causes
// RULE_20 - Load integral saturates at zero and full
// RULE_21 - Limits update only at cycle boundary
`timescale 1ns/1ns
module servo_limit_supervisor (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic cycle_tick,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic setup_in,
   input wire logic quick_stop,
   input wire logic limit_switch,
   input wire logic range_exceeded,
   input wire logic signed [servo_limit_pkg::CUR_W-1:0] cur_actual,
   input wire logic signed [servo_limit_pkg::CUR_W-1:0] cur_setpoint,
   input wire logic signed [servo_limit_pkg::CUR_W-1:0] cur_ext_limit,
   input wire logic signed [servo_limit_pkg::SPD_W-1:0] spd_setpoint,
   input wire logic signed [servo_limit_pkg::SPD_W-1:0] spd_actual,
   input wire logic [servo_limit_pkg::SPD_W-1:0] set_travel_speed,
   input wire logic signed [servo_limit_pkg::POS_W-1:0] pos_set,
   input wire logic signed [servo_limit_pkg::POS_W-1:0] pos_actual,
   input wire logic signed [servo_limit_pkg::POS_W-1:0] pos_commut,
   output logic signed [servo_limit_pkg::CUR_W-1:0] cur_limited,
   output logic signed [servo_limit_pkg::SPD_W-1:0] spd_limited,
   output logic [servo_limit_pkg::SPD_W-1:0] profile_speed,
   output logic [servo_limit_pkg::SPD_W-1:0] decel,
   output logic overspeed_err,
   output logic enc_diff_err,
   output logic follow_err
);
   localparam int CW = servo_limit_pkg::CUR_W;
   localparam int SW = servo_limit_pkg::SPD_W;
   localparam int PW = servo_limit_pkg::POS_W;
   localparam int QW = servo_limit_pkg::PCT_W;
   localparam int LW = servo_limit_pkg::LOAD_W;
   // Per-cycle load step so that zero to full takes the load time
   localparam logic [LW-1:0] LOAD_STEP_RST =
      LW'(servo_limit_pkg::LOAD_FULL / servo_limit_pkg::LOAD_TIME_CYC + 1);

   typedef struct packed {
      // Software-written shadow registers
      logic [3:0] ctrl;
      logic [CW-1:0] nom_cur;
      logic [CW-1:0] max_cur;
      logic [LW-1:0] load_step;
      logic [SW-1:0] spd_pos;
      logic [SW-1:0] spd_neg;
      logic [QW-1:0] override;
      logic [QW-1:0] setup_pct;
      logic [SW-1:0] overspeed;
      logic [PW-1:0] enc_tol;
      logic [PW-1:0] follow;
      logic [SW-1:0] dec_qstop;
      logic [SW-1:0] dec_limsw;
      logic [SW-1:0] dec_range;
      // Active copies loaded on the cycle boundary
      logic [CW-1:0] a_nom_cur;
      logic [CW-1:0] a_max_cur;
      logic [SW-1:0] a_spd_pos;
      logic [SW-1:0] a_spd_neg;
      logic [QW-1:0] a_override;
      logic [QW-1:0] a_setup_pct;
      // Pin synchronisers
      logic [1:0] setup_s1;
      logic [1:0] setup_s2;
      logic [2:0] stop_s1;
      logic [2:0] stop_s2;
      // Outputs and status
      logic [SW-1:0] lim_pos;
      logic [SW-1:0] lim_neg;
      logic [SW-1:0] setup_spd;
      logic signed [CW-1:0] cur_out;
      logic signed [SW-1:0] spd_out;
      logic [SW-1:0] prof_out;
      logic [SW-1:0] dec_out;
      logic ovs;
      logic encd;
      logic fol;
      logic [31:0] rdata;
   } sup_state_t;

   sup_state_t st;
   sup_state_t next_st;
   logic [LW-1:0] load;
   logic clamp;
   logic [CW-1:0] cur_abs;
   logic [SW-1:0] spd_abs;
   logic [SW-1:0] neg_abs;
   logic [SW-1:0] min_lim;
   logic [SW+QW-1:0] prod_setup;
   logic [SW+QW-1:0] prod_pos;
   logic [SW+QW-1:0] prod_neg;
   logic [SW+QW-1:0] prod_prof;
   logic [SW+QW-1:0] prod_res;
   logic [SW-1:0] prof_ovr;
   logic [SW-1:0] prof_res;
   logic [PW:0] enc_diff;
   logic [PW:0] fol_diff;
   logic [PW:0] enc_abs;
   logic [PW:0] fol_abs;
   logic [CW-1:0] cur_cap;
   logic signed [CW:0] cur_cap_s;
   logic signed [SW:0] spd_pos_cap;
   logic signed [SW:0] spd_neg_cap;
   logic setup_on;

   current_load_integrator u_load (
      .core_clk(core_clk),
      .rstn(rstn),
      .cycle_tick(cycle_tick),
      .cur_abs(cur_abs),
      .nom_cur(st.a_nom_cur),
      .load_step(st.load_step),
      .load(load),
      .clamp(clamp)
   );

   // Magnitudes and limit arithmetic
   always_comb begin
      cur_abs = cur_actual[CW-1] ? CW'(-cur_actual) : cur_actual;
      spd_abs = spd_actual[SW-1] ? SW'(-spd_actual) : spd_actual;
      neg_abs = st.a_spd_neg[SW-1] ? SW'(-st.a_spd_neg) : st.a_spd_neg;
      min_lim = (st.a_spd_pos < neg_abs) ? st.a_spd_pos : neg_abs; // RULE_14
      prod_setup = min_lim * st.a_setup_pct;
      prod_pos = st.a_spd_pos * st.a_override;
      prod_neg = neg_abs * st.a_override;
      // One override for every set and the homing run alike
      prod_prof = set_travel_speed * st.a_override; // RULE_06 RULE_07
      prof_ovr = SW'(prod_prof / servo_limit_pkg::PCT_FULL);
      prod_res = st.setup_spd * servo_limit_pkg::RESERVE_KEEP; // RULE_16
      prof_res = SW'(prod_res / servo_limit_pkg::PCT_FULL);
      enc_diff = {pos_actual[PW-1], pos_actual} - {pos_commut[PW-1], pos_commut};
      fol_diff = {pos_set[PW-1], pos_set} - {pos_actual[PW-1], pos_actual};
      enc_abs = enc_diff[PW] ? (PW+1)'(-enc_diff) : enc_diff;
      fol_abs = fol_diff[PW] ? (PW+1)'(-fol_diff) : fol_diff;
      // Explicit setpoint limit or motor-current limit
      if (st.ctrl[servo_limit_pkg::CTRL_TRQ_SETPT]) begin
         cur_cap = cur_ext_limit[CW-1] ? CW'(-cur_ext_limit) : cur_ext_limit; // RULE_11
      end else begin
         cur_cap = st.a_max_cur; // RULE_11
      end
      if (clamp && (st.a_nom_cur < cur_cap)) begin
         cur_cap = st.a_nom_cur; // RULE_04
      end
      cur_cap_s = {1'b0, cur_cap};
      spd_pos_cap = {1'b0, st.lim_pos};
      spd_neg_cap = -{1'b0, st.lim_neg};
      setup_on = st.setup_s2[1];
   end

   // Register file, limit computation, monitors
   always_comb begin
      next_st = st;
      next_st.rdata = '0;
      next_st.setup_s1 = {st.setup_s1[0], setup_in};
      next_st.setup_s2 = {st.setup_s2[0], st.setup_s1[1]};
      next_st.stop_s1 = {quick_stop, limit_switch, range_exceeded};
      next_st.stop_s2 = st.stop_s1;
      if (reg_wr) begin
         unique case (reg_addr)
            servo_limit_pkg::REG_CTRL: next_st.ctrl = reg_wdata[3:0];
            servo_limit_pkg::REG_NOM_CUR: next_st.nom_cur = reg_wdata[CW-1:0];
            servo_limit_pkg::REG_MAX_CUR: next_st.max_cur = reg_wdata[CW-1:0];
            servo_limit_pkg::REG_LOAD_STEP: next_st.load_step = reg_wdata[LW-1:0]; // RULE_03
            servo_limit_pkg::REG_SPD_POS: next_st.spd_pos = reg_wdata[SW-1:0];
            servo_limit_pkg::REG_SPD_NEG: next_st.spd_neg = reg_wdata[SW-1:0];
            servo_limit_pkg::REG_OVERRIDE: next_st.override = reg_wdata[QW-1:0];
            servo_limit_pkg::REG_SETUP_PCT: next_st.setup_pct = reg_wdata[QW-1:0];
            servo_limit_pkg::REG_OVERSPEED: next_st.overspeed = reg_wdata[SW-1:0];
            servo_limit_pkg::REG_ENC_TOL: next_st.enc_tol = reg_wdata[PW-1:0];
            servo_limit_pkg::REG_FOLLOW: next_st.follow = reg_wdata[PW-1:0];
            servo_limit_pkg::REG_DEC_QSTOP: next_st.dec_qstop = reg_wdata[SW-1:0];
            servo_limit_pkg::REG_DEC_LIMSW: next_st.dec_limsw = reg_wdata[SW-1:0];
            servo_limit_pkg::REG_DEC_RANGE: next_st.dec_range = reg_wdata[SW-1:0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            servo_limit_pkg::REG_CTRL: next_st.rdata = {28'h0, st.ctrl};
            servo_limit_pkg::REG_NOM_CUR: next_st.rdata = {16'h0, st.nom_cur};
            servo_limit_pkg::REG_MAX_CUR: next_st.rdata = {16'h0, st.max_cur};
            servo_limit_pkg::REG_LOAD_STEP: next_st.rdata = st.load_step;
            servo_limit_pkg::REG_SPD_POS: next_st.rdata = {8'h0, st.spd_pos};
            servo_limit_pkg::REG_SPD_NEG: next_st.rdata = {8'h0, st.spd_neg};
            servo_limit_pkg::REG_OVERRIDE: next_st.rdata = {16'h0, st.override};
            servo_limit_pkg::REG_SETUP_PCT: next_st.rdata = {16'h0, st.setup_pct};
            servo_limit_pkg::REG_OVERSPEED: next_st.rdata = {8'h0, st.overspeed};
            servo_limit_pkg::REG_ENC_TOL: next_st.rdata = st.enc_tol;
            servo_limit_pkg::REG_FOLLOW: next_st.rdata = st.follow;
            servo_limit_pkg::REG_DEC_QSTOP: next_st.rdata = {8'h0, st.dec_qstop};
            servo_limit_pkg::REG_DEC_LIMSW: next_st.rdata = {8'h0, st.dec_limsw};
            servo_limit_pkg::REG_DEC_RANGE: next_st.rdata = {8'h0, st.dec_range};
            servo_limit_pkg::REG_STATUS: next_st.rdata = {27'h0, setup_on, st.fol,
                                                          st.encd, st.ovs, clamp};
            servo_limit_pkg::REG_LOAD: next_st.rdata = load;
            servo_limit_pkg::REG_SPD_LIM: next_st.rdata = {8'h0, st.setup_spd};
            default: next_st.rdata = '0;
         endcase
      end
      // Shadow copies become active only at the cycle boundary
      if (cycle_tick) begin
         next_st.a_nom_cur = st.nom_cur; // RULE_21
         next_st.a_max_cur = st.max_cur;
         next_st.a_spd_pos = st.spd_pos;
         next_st.a_spd_neg = st.spd_neg;
         next_st.a_override = st.override;
         next_st.a_setup_pct = st.setup_pct;
         // Setup speed and effective limits
         next_st.setup_spd = SW'(prod_setup / servo_limit_pkg::PCT_FULL); // RULE_14
         next_st.lim_pos = SW'(prod_pos / servo_limit_pkg::PCT_FULL); // RULE_12
         next_st.lim_neg = SW'(prod_neg / servo_limit_pkg::PCT_FULL); // RULE_13
         // Set-up speed caps both limits while the pin is held
         if (setup_on && st.setup_spd < next_st.lim_pos) begin // RULE_15
            next_st.lim_pos = st.setup_spd; // RULE_12
         end
         if (setup_on && st.setup_spd < next_st.lim_neg) begin
            next_st.lim_neg = st.setup_spd; // RULE_13
         end
         // Current setpoint saturation
         if (cur_setpoint > cur_cap_s) begin
            next_st.cur_out = CW'(cur_cap_s);
         end else if (cur_setpoint < -cur_cap_s) begin
            next_st.cur_out = CW'(-cur_cap_s);
         end else begin
            next_st.cur_out = cur_setpoint;
         end
         // Speed setpoint saturation, setup speed included in the caps
         if (spd_setpoint > spd_pos_cap) begin
            next_st.spd_out = SW'(spd_pos_cap); // RULE_12 RULE_15
         end else if (spd_setpoint < spd_neg_cap) begin
            next_st.spd_out = SW'(spd_neg_cap); // RULE_13 RULE_15
         end else begin
            next_st.spd_out = spd_setpoint;
         end
         // Profile speed in positioning mode or during homing
         if (st.ctrl[servo_limit_pkg::CTRL_POS_MODE] ||
             st.ctrl[servo_limit_pkg::CTRL_HOMING]) begin
            next_st.prof_out = prof_ovr; // RULE_06
            if (setup_on && prof_res < prof_ovr) begin
               next_st.prof_out = prof_res; // RULE_16
            end
         end else begin
            next_st.prof_out = '0;
         end
      end
      // Monitors, live while the condition holds
      next_st.ovs = (spd_abs > st.overspeed); // RULE_09
      next_st.encd = st.ctrl[servo_limit_pkg::CTRL_ENC_DIFF] &&
                     (enc_abs > {1'b0, st.enc_tol}); // RULE_10
      next_st.fol = fol_abs > {1'b0, st.follow}; // RULE_18
      // Quick stop outranks limit switch, which outranks range exit
      if (st.stop_s2[2]) begin
         next_st.dec_out = st.dec_qstop; // RULE_19
      end else if (st.stop_s2[1]) begin
         next_st.dec_out = st.dec_limsw; // RULE_19
      end else if (st.stop_s2[0] && st.ctrl[servo_limit_pkg::CTRL_POS_MODE]) begin
         next_st.dec_out = st.dec_range; // RULE_19
      end else begin
         next_st.dec_out = '0;
      end
   end

   // State register; override is not retained across reset
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st <= '0;
         st.nom_cur <= servo_limit_pkg::NOM_CUR_RST;
         st.max_cur <= servo_limit_pkg::MAX_CUR_RST;
         st.load_step <= LOAD_STEP_RST;
         st.spd_pos <= servo_limit_pkg::SPD_LIM_RST;
         st.spd_neg <= SW'(-servo_limit_pkg::SPD_LIM_RST);
         st.override <= servo_limit_pkg::OVR_RESET; // RULE_08
         st.a_override <= servo_limit_pkg::OVR_RESET; // RULE_08
         st.setup_pct <= servo_limit_pkg::SETUP_PCT_RST;
         st.overspeed <= servo_limit_pkg::OVERSPEED_RST;
         st.enc_tol <= servo_limit_pkg::ENC_TOL_RST;
         st.follow <= servo_limit_pkg::FOLLOW_RST;
         st.dec_qstop <= servo_limit_pkg::DEC_RST;
         st.dec_limsw <= servo_limit_pkg::DEC_RST;
         st.dec_range <= servo_limit_pkg::DEC_RST;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign cur_limited = st.cur_out;
   assign spd_limited = st.spd_out;
   assign profile_speed = st.prof_out;
   assign decel = st.dec_out;
   assign overspeed_err = st.ovs;
   assign enc_diff_err = st.encd;
   assign follow_err = st.fol;
endmodule : servo_limit_supervisor

// [verif/motor_model.sv]
// Behavioural motor with current, speed and encoder feedback
`timescale 1ns/1ns
module motor_model (
   input wire logic core_clk,
   input wire logic signed [15:0] cur_cmd,
   input wire logic signed [23:0] spd_cmd,
   input wire logic signed [23:0] spd_bias,
   input wire logic signed [31:0] pos_cmd,
   input wire logic signed [31:0] pos_lag,
   input wire logic signed [31:0] enc_skew,
   output logic signed [15:0] cur_fb,
   output logic signed [23:0] spd_fb,
   output logic signed [31:0] pos_fb,
   output logic signed [31:0] commut_fb
);
   // One clock of plant lag
   always_ff @(posedge core_clk) begin
      cur_fb <= cur_cmd;
      spd_fb <= spd_cmd + spd_bias;
      pos_fb <= pos_cmd - pos_lag;
      commut_fb <= pos_cmd - pos_lag + enc_skew;
   end
endmodule : motor_model

// [verif/servo_limit_monitor.sv]
// Port checker for the servo limit supervisor
`timescale 1ns/1ns
module servo_limit_monitor (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic cycle_tick,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic quick_stop,
   input wire logic limit_switch,
   input wire logic range_exceeded,
   input wire logic signed [15:0] cur_limited,
   input wire logic signed [23:0] spd_limited,
   input wire logic signed [23:0] spd_actual,
   input wire logic [23:0] profile_speed,
   input wire logic [23:0] decel,
   input wire logic signed [31:0] pos_set,
   input wire logic signed [31:0] pos_actual,
   input wire logic signed [31:0] pos_commut,
   input wire logic overspeed_err,
   input wire logic enc_diff_err,
   input wire logic follow_err
);
   logic ovs_c, enc_c, fol_c, no_stop, quiet;
   function automatic longint mag(input longint v);
      return v < 0 ? -v : v;
   endfunction : mag
   // Faults against reset thresholds; the bench keeps them
   always_comb begin
      ovs_c = mag(spd_actual) > servo_limit_pkg::OVERSPEED_RST;
      enc_c = mag(longint'(pos_actual) - pos_commut) > servo_limit_pkg::ENC_TOL_RST;
      fol_c = mag(longint'(pos_set) - pos_actual) > servo_limit_pkg::FOLLOW_RST;
      no_stop = !(quick_stop || limit_switch || range_exceeded);
   end
   // Last edge saw neither reset nor tick
   always_ff @(posedge core_clk) quiet <= rstn && !cycle_tick;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
   property p_ovs; $past(rstn) |-> overspeed_err == $past(ovs_c); endproperty
   property p_enc; enc_diff_err |-> $past(enc_c); endproperty
   property p_fol; $past(rstn) |-> follow_err == $past(fol_c); endproperty
   property p_cur_hold; quiet |-> $stable(cur_limited); endproperty
   property p_spd_hold; quiet |-> $stable(spd_limited); endproperty
   property p_prof_hold; quiet |-> $stable(profile_speed); endproperty
   property p_decel_idle; no_stop [*4] |-> decel == 24'h0; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
   a_ovs: assert property (p_ovs) else $error("overspeed flag wrong");
   a_enc: assert property (p_enc) else $error("encoder flag without cause");
   a_fol: assert property (p_fol) else $error("following flag wrong");
   a_cur_hold: assert property (p_cur_hold) else $error("current moved off tick");
   a_spd_hold: assert property (p_spd_hold) else $error("speed moved off tick");
   a_prof_hold: assert property (p_prof_hold) else $error("profile moved off tick");
   a_decel_idle: assert property (p_decel_idle) else $error("decel without stop");
   c_ovs: cover property (overspeed_err);
   c_fol: cover property (follow_err);
   c_decel: cover property (decel != 24'h0);
endmodule : servo_limit_monitor
bind servo_limit_supervisor servo_limit_monitor mon (.core_clk, .rstn, .cycle_tick, .reg_rd,
   .reg_rdata, .quick_stop, .limit_switch, .range_exceeded, .cur_limited, .spd_limited,
   .spd_actual, .profile_speed, .decel, .pos_set, .pos_actual, .pos_commut, .overspeed_err,
   .enc_diff_err, .follow_err);

// [verif/servo_limit_supervisor_test.sv]
// Register-driven bench for the servo limit supervisor
`timescale 1ns/1ns
module servo_limit_supervisor_test;
   localparam logic [31:0] SU = 32'h800 * servo_limit_pkg::SETUP_PCT_RST / 32'h2710;
   logic core_clk = 1'b0, rstn = 1'b0, cycle_tick = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0, reg_rdata;
   logic setup_in = '0, quick_stop = '0, limit_switch = '0, range_exceeded = '0;
   logic signed [15:0] cur_actual, cur_setpoint = '0, cur_ext_limit = '0, cur_limited;
   logic signed [23:0] spd_setpoint = '0, spd_bias = '0, spd_actual, spd_limited;
   logic [23:0] set_travel_speed = '0, profile_speed, decel;
   logic signed [31:0] pos_set = '0, pos_lag = '0, enc_skew = '0, pos_actual;
   logic signed [31:0] pos_commut;
   logic overspeed_err, enc_diff_err, follow_err;
   int miscompares = 0, comparisons = 0;
   servo_limit_supervisor uut (.core_clk, .rstn, .cycle_tick, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .setup_in, .quick_stop, .limit_switch, .range_exceeded, .cur_actual,
      .cur_setpoint, .cur_ext_limit, .spd_setpoint, .spd_actual, .set_travel_speed, .pos_set,
      .pos_actual, .pos_commut, .cur_limited, .spd_limited, .profile_speed, .decel,
      .overspeed_err, .enc_diff_err, .follow_err);
   motor_model motor (.core_clk(core_clk), .cur_cmd(cur_limited), .spd_cmd(spd_limited),
      .spd_bias(spd_bias), .pos_cmd(pos_set), .pos_lag(pos_lag), .enc_skew(enc_skew),
      .cur_fb(cur_actual), .spd_fb(spd_actual), .pos_fb(pos_actual), .commut_fb(pos_commut));
   // 50 MHz clock
   initial forever #10 core_clk = ~core_clk;
   task automatic finish_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rst;
      rstn <= 1'b0;
      repeat (4) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge core_clk);
   endtask : rst
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      // Gap edge, so a following write never re-raises the strobe in this step
      @(posedge core_clk);
   endtask : wr
   // Data stands the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask : rd
   // Ticks spaced for feedback to settle
   task automatic tick(input int n);
      repeat (n) begin
         cycle_tick <= 1'b1;
         @(posedge core_clk);
         cycle_tick <= 1'b0;
         repeat (5) @(posedge core_clk);
      end
      #1;
   endtask : tick
   // Hang guard
   initial begin
      #200us;
      miscompares++;
      finish_test;
   end
   initial begin
      rst;
      rd(servo_limit_pkg::REG_OVERRIDE, servo_limit_pkg::OVR_RESET);
      wr(servo_limit_pkg::REG_OVERRIDE, 32'h1388);
      rst;
      rd(servo_limit_pkg::REG_OVERRIDE, servo_limit_pkg::OVR_RESET);
      rd(8'hfc, 32'h0);
      $display("test override reset done");
      wr(servo_limit_pkg::REG_LOAD_STEP, 32'h1000_0000);
      cur_setpoint <= 16'sh0300;
      tick(2);
      chk(cur_limited, 32'h200);
      tick(8);
      rd(servo_limit_pkg::REG_LOAD, servo_limit_pkg::LOAD_FULL);
      chk(cur_limited, servo_limit_pkg::NOM_CUR_RST);
      cur_setpoint <= 16'sh0080;
      tick(2);
      cur_setpoint <= 16'sh0300;
      tick(3);
      chk(cur_limited, servo_limit_pkg::NOM_CUR_RST);
      rd(servo_limit_pkg::REG_STATUS, 32'h1);
      cur_setpoint <= 16'sh0080;
      tick(8);
      rd(servo_limit_pkg::REG_LOAD, 32'h0);
      cur_setpoint <= 16'sh0180;
      tick(2);
      chk(cur_limited, 32'h180);
      wr(servo_limit_pkg::REG_CTRL, 32'h2);
      cur_ext_limit <= 16'sh00c0;
      cur_setpoint <= -16'sh0180;
      tick(3);
      chk(cur_limited, 32'hffff_ff40);
      $display("test current load done");
      wr(servo_limit_pkg::REG_CTRL, 32'h0);
      wr(servo_limit_pkg::REG_SPD_NEG, 32'hffff_f800);
      spd_setpoint <= 24'sh002000;
      tick(3);
      chk(spd_limited, 32'h1000);
      spd_setpoint <= -24'sh002000;
      tick(2);
      chk(spd_limited, 32'hffff_f800);
      rd(servo_limit_pkg::REG_SPD_LIM, SU);
      setup_in <= 1'b1;
      tick(3);
      chk(spd_limited, -SU);
      setup_in <= 1'b0;
      spd_setpoint <= 24'sh001000;
      spd_bias <= 24'sh001000;
      tick(3);
      chk(overspeed_err, 32'h0);
      spd_bias <= 24'sh001001;
      tick(1);
      chk(overspeed_err, 32'h1);
      spd_bias <= 24'sh0;
      $display("test speed limits done");
      wr(servo_limit_pkg::REG_CTRL, 32'h1);
      wr(servo_limit_pkg::REG_OVERRIDE, 32'h1388);
      set_travel_speed <= 24'h000800;
      tick(3);
      chk(profile_speed, 32'h400);
      wr(servo_limit_pkg::REG_CTRL, 32'h8);
      tick(3);
      chk(profile_speed, 32'h400);
      setup_in <= 1'b1;
      tick(3);
      chk(profile_speed, SU * servo_limit_pkg::RESERVE_KEEP / 32'h2710);
      $display("test positioning done");
      wr(servo_limit_pkg::REG_CTRL, 32'h5);
      enc_skew <= 32'sh1000;
      tick(2);
      chk(enc_diff_err, 32'h0);
      enc_skew <= 32'sh1001;
      tick(1);
      chk(enc_diff_err, 32'h1);
      pos_lag <= 32'sh8001;
      tick(1);
      chk(follow_err, 32'h1);
      pos_lag <= 32'sh8000;
      tick(1);
      chk(follow_err, 32'h0);
      wr(servo_limit_pkg::REG_DEC_QSTOP, 32'h11);
      wr(servo_limit_pkg::REG_DEC_LIMSW, 32'h22);
      wr(servo_limit_pkg::REG_DEC_RANGE, 32'h33);
      // Stop causes drop, highest first
      for (int i = 0; i < 4; i++) begin
         {quick_stop, limit_switch, range_exceeded} <= 3'b111 >> i;
         tick(2);
         chk(decel, i < 3 ? 32'h11 * (i + 1) : 32'h0);
      end
      $display("test monitors done");
      finish_test;
   end
endmodule : servo_limit_supervisor_test
